// ===== hdl/stt_pkg.sv
// shared constants and types for the system tick timer
package stt_pkg;
   localparam int unsigned STT_ADDR_W = 12;
   localparam int unsigned STT_DATA_W = 32;
   localparam int unsigned STT_COUNT_W = 24;

   localparam logic [11:0] STT_OFS_CTRL = 12'h010;
   localparam logic [11:0] STT_OFS_RELOAD = 12'h014;
   localparam logic [11:0] STT_OFS_CURRENT = 12'h018;
   localparam logic [11:0] STT_OFS_CALIB = 12'h01C;

   localparam int unsigned STT_BIT_ENABLE = 0;
   localparam int unsigned STT_BIT_TICKINT = 1;
   localparam int unsigned STT_BIT_CLKSRC = 2;
   localparam int unsigned STT_BIT_WRAP = 16;

   localparam logic [31:0] STT_RST_CTRL = 32'h0000_0000;
   localparam logic [23:0] STT_RST_RELOAD = 24'h00_0000;
   localparam logic [23:0] STT_RST_CURRENT = 24'h00_0000;
   localparam logic [31:0] STT_RST_CALIB = 32'h0000_0004;
   localparam logic [31:0] STT_READ_NONE = 32'h0000_0000;
   localparam logic [7:0] STT_RSVD_ZERO = 8'h00;

   // tick divider: one tick per this many system clocks
   localparam int unsigned STT_TICK_DIV = 2;

   typedef struct packed {
      logic clk_source;
      logic tick_int;
      logic enable;
   } stt_ctrl_t;

   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic rd;
      logic [31:0] wdata;
   } stt_req_t;
endpackage : stt_pkg

// ===== hdl/stt_tick_gen.sv
// tick source: half system clock or synchronised external reference
`timescale 1ns/1ps
module stt_tick_gen
   import stt_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic enable_i,
   input wire logic use_half_i,
   input wire logic ref_i,
   output logic tick_o
);
   logic phase;
   logic ref_meta;
   logic ref_sync;
   logic ref_prev;

   // phase restarts on disable so the first tick lands one clock after enable
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         phase <= 1'b0;
      else if (!enable_i)
         phase <= 1'b0;
      else
         phase <= ~phase;
   end

   // reference pin comes from outside the clock domain
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ref_meta <= 1'b0;
         ref_sync <= 1'b0;
         ref_prev <= 1'b0;
      end
      else
      begin
         ref_meta <= ref_i;
         ref_sync <= ref_meta;
         ref_prev <= ref_sync;
      end
   end

   assign tick_o = enable_i & (use_half_i ? phase : (ref_sync & ~ref_prev));

   chk_half_alternate: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick_o && use_half_i && enable_i) |=> !tick_o)
      else $error("half-rate tick fired on two adjacent clocks");
   chk_half_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
      (tick_o && use_half_i && enable_i) ##1 (use_half_i && enable_i) ##1 (use_half_i && enable_i) |-> tick_o)
      else $error("half-rate tick missing after two clocks");
endmodule : stt_tick_gen

// ===== hdl/stt_timer.sv
// system tick timer: 24-bit down counter with register port
// Operation
// - reload counter from reload field at zero
// - current value read returns live count
// - current value write clears count and flag
// - control register holds controls and wrap flag
// - calibration reads mirror configuration block value
// - reserved upper bits never written with ones
// - 24-bit down count, interrupt at zero if enabled
// - tick is half the system clock when the clock source bit is set, else the synchronised external reference edge
`timescale 1ns/1ps
module stt_timer
   import stt_pkg::*;
#(
   parameter int unsigned COUNT_W = STT_COUNT_W
)
(
   input wire logic CLK_SYS_I,
   input wire logic RST_I,
   input wire logic [STT_ADDR_W-1:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [STT_DATA_W-1:0] REG_WDATA_I,
   output logic [STT_DATA_W-1:0] REG_RDATA_O,
   input wire logic [STT_DATA_W-1:0] SYSCFG_CALIB_I,
   input wire logic TICK_REF_I,
   output logic TICK_IRQ_O
);
   stt_req_t req;
   stt_ctrl_t ctrl;
   logic wrap_flag;
   logic [COUNT_W-1:0] reload;
   logic [COUNT_W-1:0] count;
   logic tick;
   logic tick_ok;
   logic hit_zero;
   logic ctrl_wr;
   logic ctrl_rd;
   logic reload_wr;
   logic current_wr;
   logic [STT_DATA_W-1:0] next_rdata;

   function automatic logic sel(input logic [11:0] addr, input logic [11:0] ofs);
      sel = (addr == ofs);
   endfunction : sel

   assign req = '{addr: REG_ADDR_I, wr: REG_WR_I, rd: REG_RD_I, wdata: REG_WDATA_I};
   assign ctrl_wr = req.wr && sel(req.addr, STT_OFS_CTRL);
   assign ctrl_rd = req.rd && sel(req.addr, STT_OFS_CTRL);
   assign reload_wr = req.wr && sel(req.addr, STT_OFS_RELOAD);
   assign current_wr = req.wr && sel(req.addr, STT_OFS_CURRENT);

   stt_tick_gen u_tick
   (
      .clk_i(CLK_SYS_I),
      .rst_i(RST_I),
      .enable_i(ctrl.enable),
      .use_half_i(ctrl.clk_source),
      .ref_i(TICK_REF_I),
      .tick_o(tick)
   );

   assign tick_ok = tick && ctrl.enable;
   // zero is reached by decrementing from one; a clearing write overrides the tick
   assign hit_zero = tick_ok && !current_wr && (count == COUNT_W'(1));

   // control bits
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         ctrl <= '0;
      else if (ctrl_wr)
      begin
         ctrl.enable <= req.wdata[STT_BIT_ENABLE];
         ctrl.tick_int <= req.wdata[STT_BIT_TICKINT];
         ctrl.clk_source <= req.wdata[STT_BIT_CLKSRC];
      end
   end

   // wrap flag: a zero-reach in a control-read cycle still sets it
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         wrap_flag <= STT_RST_CTRL[STT_BIT_WRAP];
      else if (hit_zero)
         wrap_flag <= 1'b1;
      else if (ctrl_rd || current_wr)
         wrap_flag <= 1'b0;
   end

   // upper reserved bits of the write are dropped, not stored
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         reload <= STT_RST_RELOAD;
      else if (reload_wr)
         reload <= req.wdata[COUNT_W-1:0];
   end

   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         count <= STT_RST_CURRENT;
      else if (current_wr)
         count <= '0;
      else if (tick_ok)
      begin
         if (count == '0)
            count <= reload;
         else
            count <= count - COUNT_W'(1);
      end
   end

   // interrupt request is a one-clock pulse per zero-reach while tick_int is set
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         TICK_IRQ_O <= 1'b0;
      else
         TICK_IRQ_O <= hit_zero && ctrl.tick_int;
   end

   always_comb
   begin
      next_rdata = STT_READ_NONE;
      unique case (1'b1)
         sel(req.addr, STT_OFS_CTRL):
         begin
            next_rdata[STT_BIT_ENABLE] = ctrl.enable;
            next_rdata[STT_BIT_TICKINT] = ctrl.tick_int;
            next_rdata[STT_BIT_CLKSRC] = ctrl.clk_source;
            next_rdata[STT_BIT_WRAP] = wrap_flag;
         end
         sel(req.addr, STT_OFS_RELOAD):
            next_rdata = {STT_RSVD_ZERO, reload};
         sel(req.addr, STT_OFS_CURRENT):
            next_rdata = {STT_RSVD_ZERO, count};
         sel(req.addr, STT_OFS_CALIB):
            next_rdata = SYSCFG_CALIB_I;
         default:
            next_rdata = STT_READ_NONE;
      endcase
   end

   // read data is held until the next read strobe
   always_ff @(posedge CLK_SYS_I or posedge RST_I)
   begin
      if (RST_I)
         REG_RDATA_O <= STT_READ_NONE;
      else if (req.rd)
         REG_RDATA_O <= next_rdata;
   end

   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (RST_I);

   chk_reload_at_zero: assert property (
      (tick_ok && !current_wr && count == '0) |=> count == $past(reload))
      else $error("counter did not reload at zero");
   chk_count_down: assert property (
      (tick_ok && !current_wr && count != '0) |=> count == $past(count) - COUNT_W'(1))
      else $error("counter did not decrement on tick");
   chk_count_hold: assert property (
      (!tick_ok && !current_wr) |=> $stable(count))
      else $error("counter moved without a tick");
   chk_current_read: assert property (
      (req.rd && req.addr == STT_OFS_CURRENT) |=> REG_RDATA_O == {STT_RSVD_ZERO, $past(count)})
      else $error("current value read returned wrong count");
   chk_current_clear: assert property (
      current_wr |=> (count == '0) && (wrap_flag == $past(hit_zero)))
      else $error("current value write did not clear count and flag");
   chk_flag_set: assert property (
      hit_zero |=> wrap_flag ##1 (wrap_flag || $past(ctrl_rd) || $past(current_wr)))
      else $error("wrap flag not set or lost without a clear");
   chk_flag_read_clear: assert property (
      (ctrl_rd && !hit_zero) |=> !wrap_flag)
      else $error("control read did not clear wrap flag");
   chk_calib_mirror: assert property (
      (req.rd && req.addr == STT_OFS_CALIB) |=> REG_RDATA_O == $past(SYSCFG_CALIB_I))
      else $error("calibration read does not mirror input");
   chk_reload_upper: assert property (
      (req.rd && (req.addr == STT_OFS_RELOAD || req.addr == STT_OFS_CURRENT)) |=> REG_RDATA_O[31:24] == '0)
      else $error("reserved bits read nonzero");
   chk_irq_cause: assert property (
      TICK_IRQ_O |-> $past(hit_zero) && $past(ctrl.tick_int))
      else $error("interrupt without enabled zero-reach");

   // register port: writes land one edge after the strobe, read data stands until the next read
   chk_ctrl_write: assert property (
      ctrl_wr |=> {ctrl.clk_source, ctrl.tick_int, ctrl.enable} == $past(req.wdata[2:0]))
      else $error("control write did not land");
   chk_ctrl_read: assert property (
      (req.rd && req.addr == STT_OFS_CTRL) |=> REG_RDATA_O == {15'h0000, $past(wrap_flag), 13'h0000,
      $past(ctrl.clk_source), $past(ctrl.tick_int), $past(ctrl.enable)})
      else $error("control read returned wrong bits");
   chk_reload_write: assert property (
      reload_wr |=> reload == $past(req.wdata[COUNT_W-1:0]))
      else $error("reload write did not land");
   chk_rdata_hold: assert property (
      !req.rd |=> $stable(REG_RDATA_O))
      else $error("read data changed without a read");

   // flag and interrupt: a zero-reach cannot repeat on the next clock, ticks are never adjacent while the clock source bit is unchanged
   chk_flag_hold: assert property (
      (!hit_zero && !ctrl_rd && !current_wr) |=> $stable(wrap_flag))
      else $error("wrap flag changed without a cause");
   chk_irq_single: assert property (
      TICK_IRQ_O |=> !TICK_IRQ_O)
      else $error("interrupt pulse longer than one clock");
   chk_irq_masked: assert property (
      (hit_zero && !ctrl.tick_int) |=> !TICK_IRQ_O)
      else $error("interrupt raised while masked");
   chk_stopped_quiet: assert property (
      !ctrl.enable |=> !TICK_IRQ_O)
      else $error("interrupt raised while counting is off");

   cov_zero_reach: cover property (hit_zero && ctrl.tick_int ##1 TICK_IRQ_O);
   cov_flag_read: cover property (wrap_flag ##1 ctrl_rd ##1 !wrap_flag);
   cov_clear_race: cover property (hit_zero && ctrl_rd);
   cov_reload_wrap: cover property (tick_ok && count == '0 && reload != '0);
endmodule : stt_timer

// ===== verif/testbench.sv
// self-checking bench for the system tick timer
`timescale 1ns/1ps
module testbench;
   import stt_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [31:0] calib = STT_RST_CALIB;
   logic tick_ref = 1'b0;
   logic irq;
   logic ref_mode = 1'b0;
   logic [15:0] seed = 16'h3EAE;
   logic [15:0] rnd;
   logic [31:0] ctl;
   logic [31:0] rl;
   logic hit;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   int n;
   int modes[$] = '{7, 3, 5, 7};

   stt_timer stt_timer_i (.CLK_SYS_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SYSCFG_CALIB_I(calib), .TICK_REF_I(tick_ref),
      .TICK_IRQ_O(irq));

   initial
   begin
      forever #5 clk = ~clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction : lfsr

   task automatic final_report();
      if (failures == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report

   // reference rises every 8 clocks in external mode; noise otherwise, which must be ignored
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      tick_ref <= ref_mode ? ((cycles % 8) < 4) : seed[0];
      if (cycles == 20000)
      begin
         failures = failures + 1;
         final_report();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask : reg_wr

   task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input string what);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(what, exp, rdata);
      @(posedge clk);
   endtask : reg_rd

   // returns clocks until the next interrupt pulse is sampled
   task automatic wait_irq(output int k);
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (irq !== 1'b1 && k < 5000);
   endtask : wait_irq

   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      reg_rd(STT_OFS_CTRL, 32'h0000_0000, "ctrl reset");
      reg_rd(STT_OFS_RELOAD, 32'h0000_0000, "reload reset");
      reg_rd(STT_OFS_CURRENT, 32'h0000_0000, "current reset");
      reg_rd(STT_OFS_CALIB, 32'h0000_0004, "calib reset");
      reg_rd(12'h020, 32'h0000_0000, "unmapped");
      foreach (modes[i])
      begin
         rnd = lfsr(seed);
         seed <= rnd;
         ctl = 32'(modes[i]);
         rl = (i == 3) ? (STT_RST_CALIB & 32'h00FF_FFFF) : ({27'h0, rnd[4:0]} + 32'h0000_0008);
         calib <= (i == 3) ? STT_RST_CALIB : {rnd, ~rnd};
         reg_wr(STT_OFS_CTRL, 32'h0000_0000);
         ref_mode <= ~ctl[2];
         reg_wr(STT_OFS_CALIB, 32'hC0FF_FFFF);
         reg_rd(STT_OFS_CALIB, (i == 3) ? STT_RST_CALIB : {rnd, ~rnd}, "calib");
         // last pass loads the calibration value just read as the reload
         reg_wr(STT_OFS_RELOAD, (i == 3) ? (rdata & 32'h00FF_FFFF) : rl);
         reg_rd(STT_OFS_RELOAD, rl, "reload");
         reg_wr(STT_OFS_CURRENT, {16'h0000, rnd});
         reg_rd(STT_OFS_CURRENT, 32'h0000_0000, "current clear");
         reg_wr(STT_OFS_CTRL, ctl);
         if (ctl[1])
         begin
            wait_irq(n);
            wait_irq(n);
            check("period", 32'((ctl[2] ? 2 : 8) * (rl + 1)), 32'(n));
            if (ctl[2])
            begin
               // reload lands two clocks after the pulse, then one step per two clocks
               repeat (3) @(posedge clk);
               reg_rd(STT_OFS_CURRENT, rl - 32'h0000_0001, "live count");
            end
         end
         else
         begin
            hit = 1'b0;
            repeat (4 * (rl + 1))
            begin
               @(posedge clk);
               if (irq !== 1'b0)
                  hit = 1'b1;
            end
            check("masked irq", 32'h0000_0000, {31'h0, hit});
         end
         reg_wr(STT_OFS_CTRL, ctl & 32'h0000_0006);
         if (i == 3)
            reg_wr(STT_OFS_CURRENT, 32'h0000_0000);
         reg_rd(STT_OFS_CTRL, (i == 3 ? 32'h0 : 32'h0001_0000) | (ctl & 32'h6), "wrap flag");
         reg_rd(STT_OFS_CTRL, ctl & 32'h0000_0006, "flag after read");
      end
      final_report();
   end
endmodule : testbench
